// File: rtl/crystal_gate_ctrl.sv
// Functional notes
// - crystal control bit 7 enables the crystal amplifier; 0 disables it
// - with bit 5 set and amplifier enabled, crystal keeps running in stop mode
// - keep-alive bit ignored while the internal clock generator requests the amplifier
// - bit 4 selects output clock: 0 crystal input pin, 1 amplified crystal
// - bit 2 selects frequency range: 0 low kHz range, 1 high MHz range
// - bit 1 selects amplifier gain: 0 low, 1 high
// - bit 0 read-only, set once crystal start-up cycles complete
// - reserved bits read 0: control bits 6,3; first gating bits 6,4-2
// - four 8-bit read/write gating registers at consecutive addresses
// - first three gating registers reset to A3h, 3Ch, 36h
// - fourth gating register resets to A9h
// - first gating bit 7 enables flexible timer 2 bus clock
// - first gating bit 5 enables flexible timer 0 bus clock
// - first gating bit 1 enables modulo timer 0 bus clock
// - first gating bit 0 enables real-time clock bus clock
//
// Added by the designer: register access over AXI4-Lite.
`include "crystal_gate_defs.svh"

module crystal_gate_ctrl
  import crystal_gate_pkg::*;
#(
  parameter int STARTUP_CYCLES = `STARTUP_CYCLES
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [15:0] awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  // axi4-lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // axi4-lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read address
  input  wire logic [15:0] araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  // axi4-lite read data
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // system and analog side
  input  wire logic        stop_mode,
  input  wire logic        icg_amp_request,
  input  wire logic        crystal_input_pin,
  input  wire logic        crystal_amp_clk,
  // crystal control
  output xtal_ctrl_t       xtal_ctrl,
  // bus clock enables
  output gate_ctrl_t       gate_ctrl,
  // interrupt
  output logic             irq
);

  state_t q;
  state_t d;

  logic       amp_run;
  logic [7:0] rd_byte;
  logic       rd_hit;
  logic       wr_hit;
  logic [7:0] ev_set;
  logic       ev_clear;
  logic       amp_edge;

  function automatic logic idx_mapped(input logic [13:0] idx);
    idx_mapped = (idx == `IDX_GATING_TIMERS) || (idx == `IDX_GATING_TWO) ||
                 (idx == `IDX_GATING_THREE) || (idx == `IDX_GATING_FOUR) ||
                 (idx == `IDX_CRYSTAL_SC) || (idx == `IDX_EVENT_STATUS) ||
                 (idx == `IDX_EVENT_MASK);
  endfunction

  // status register view; reserved bits forced low
  function automatic logic [7:0] read_reg(input state_t s, input logic [13:0] idx);
    logic [7:0] v;
    v = 8'h00;
    unique case (idx)
      `IDX_GATING_TIMERS: v = s.gating_timers & `MASK_GATING_TIMERS;
      `IDX_GATING_TWO:    v = s.gating_two & `MASK_GATING_TWO;
      `IDX_GATING_THREE:  v = s.gating_three & `MASK_GATING_THREE;
      `IDX_GATING_FOUR:   v = s.gating_four & `MASK_GATING_FOUR;
      `IDX_CRYSTAL_SC: begin
        v = s.crystal_sc & `MASK_CRYSTAL_SC;
        v[`BIT_STARTUP_DONE] = (s.st == ST_RUNNING);
      end
      `IDX_EVENT_STATUS:  v = s.ev_status & `MASK_EVENTS;
      `IDX_EVENT_MASK:    v = s.ev_mask & `MASK_EVENTS;
      default:            v = 8'h00;
    endcase
    read_reg = v;
  endfunction

  // icg request forces the amplifier on whatever the keep-alive bit says
  assign amp_run = icg_amp_request |
                   (q.crystal_sc[`BIT_AMP_ENABLE] &
                    (~stop_mode | q.crystal_sc[`BIT_STOP_KEEPALIVE]));

  assign amp_edge = crystal_amp_clk & ~q.amp_clk_prev;

  assign awready = ~q.aw_have & ~q.bvalid;
  assign wready  = ~q.w_have & ~q.bvalid;
  assign arready = ~q.rvalid;

  always_comb begin
    d        = q;
    rd_byte  = 8'h00;
    rd_hit   = 1'b0;
    wr_hit   = 1'b0;
    ev_set   = 8'h00;
    ev_clear = 1'b0;

    d.amp_clk_prev = crystal_amp_clk;

    // write channels taken in either order
    if (awvalid && awready) begin
      d.aw_have = 1'b1;
      d.aw_idx  = awaddr[15:2];
    end
    if (wvalid && wready) begin
      d.w_have = 1'b1;
      d.w_data = wdata[7:0];
      d.w_lane = wstrb[0];
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end

    // only byte lane 0 carries data; upper lanes are ignored
    if (q.aw_have && q.w_have && !q.bvalid) begin
      wr_hit    = idx_mapped(q.aw_idx);
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = wr_hit ? `RESP_OKAY : `RESP_DECERR;
      if (wr_hit && q.w_lane) begin
        unique case (q.aw_idx)
          `IDX_GATING_TIMERS: d.gating_timers = q.w_data & `MASK_GATING_TIMERS;
          `IDX_GATING_TWO:    d.gating_two = q.w_data & `MASK_GATING_TWO;
          `IDX_GATING_THREE:  d.gating_three = q.w_data & `MASK_GATING_THREE;
          `IDX_GATING_FOUR:   d.gating_four = q.w_data & `MASK_GATING_FOUR;
          `IDX_CRYSTAL_SC:    d.crystal_sc = q.w_data & `MASK_CRYSTAL_SC;
          `IDX_EVENT_MASK:    d.ev_mask = q.w_data & `MASK_EVENTS;
          default:            d.ev_mask = q.ev_mask;
        endcase
      end
    end

    // read channel
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      rd_hit   = idx_mapped(araddr[15:2]);
      rd_byte  = read_reg(q, araddr[15:2]);
      d.rvalid = 1'b1;
      d.rdata  = rd_byte;
      d.rresp  = rd_hit ? `RESP_OKAY : `RESP_DECERR;
      ev_clear = (araddr[15:2] == `IDX_EVENT_STATUS);
    end

    // crystal start-up sequencer, counts amplifier clock edges
    unique case (q.st)
      ST_OFF: begin
        d.cycles = 13'h0000;
        if (amp_run) begin
          d.st = ST_STARTING;
        end
      end
      ST_STARTING: begin
        if (!amp_run) begin
          d.st     = ST_OFF;
          d.cycles = 13'h0000;
        end else if (amp_edge) begin
          if (q.cycles == 13'(STARTUP_CYCLES - 1)) begin
            d.st               = ST_RUNNING;
            ev_set[`BIT_EV_STARTED] = 1'b1;
          end else begin
            d.cycles = q.cycles + 13'h0001;
          end
        end
      end
      ST_RUNNING: begin
        if (!amp_run) begin
          d.st                    = ST_OFF;
          ev_set[`BIT_EV_STOPPED] = 1'b1;
        end
      end
      default: begin
        d.st     = ST_OFF;
        d.cycles = 13'h0000;
      end
    endcase

    // set wins over the read clear
    d.ev_status = ((ev_clear ? 8'h00 : q.ev_status) | ev_set) & `MASK_EVENTS;
    d.irq       = |(d.ev_status & q.ev_mask);

    // a stopped amplifier yields no clock
    d.clk_out = q.crystal_sc[`BIT_OUTPUT_SELECT] ? (crystal_amp_clk & amp_run)
                                                 : crystal_input_pin;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q               <= '0;
      q.gating_timers <= `RST_GATING_TIMERS;
      q.gating_two    <= `RST_GATING_TWO;
      q.gating_three  <= `RST_GATING_THREE;
      q.gating_four   <= `RST_GATING_FOUR;
      q.crystal_sc    <= `RST_CRYSTAL_SC;
      q.ev_mask       <= `RST_EVENT_MASK;
      q.st            <= ST_OFF;
      q.bresp         <= `RESP_OKAY;
      q.rresp         <= `RESP_OKAY;
    end else begin
      q <= d;
    end
  end

  // axi outputs
  assign bvalid = q.bvalid;
  assign bresp  = q.bresp;
  assign rvalid = q.rvalid;
  assign rresp  = q.rresp;
  assign rdata  = {24'h000000, q.rdata};
  assign irq    = q.irq;

  // crystal control
  assign xtal_ctrl.amp_on        = amp_run;
  assign xtal_ctrl.amp_high_gain = q.crystal_sc[`BIT_HIGH_GAIN];
  assign xtal_ctrl.range_high    = q.crystal_sc[`BIT_RANGE_HIGH];
  assign xtal_ctrl.output_select = q.crystal_sc[`BIT_OUTPUT_SELECT];
  assign xtal_ctrl.startup_done  = (q.st == ST_RUNNING);
  assign xtal_ctrl.clk_out       = q.clk_out;

  // enables straight from flops change only at a rising edge, so the
  // peripheral's enable-based gate never sees a partial pulse
  assign gate_ctrl.flex_timer_two_gate    = q.gating_timers[`BIT_FLEX_TIMER_TWO];
  assign gate_ctrl.flex_timer_zero_gate   = q.gating_timers[`BIT_FLEX_TIMER_ZERO];
  assign gate_ctrl.modulo_timer_zero_gate = q.gating_timers[`BIT_MODULO_TIMER];
  assign gate_ctrl.rtc_gate               = q.gating_timers[`BIT_RTC];
  assign gate_ctrl.gate_two               = q.gating_two;
  assign gate_ctrl.gate_three             = q.gating_three;
  assign gate_ctrl.gate_four              = q.gating_four;

endmodule

// File: rtl/crystal_gate_defs.svh
`ifndef CRYSTAL_GATE_DEFS_SVH
`define CRYSTAL_GATE_DEFS_SVH

// register indices; byte address is four times the index
`define IDX_GATING_TIMERS    14'h300C
`define IDX_GATING_TWO       14'h300D
`define IDX_GATING_THREE     14'h300E
`define IDX_GATING_FOUR      14'h300F
`define IDX_CRYSTAL_SC       14'h303E
`define IDX_EVENT_STATUS     14'h3040
`define IDX_EVENT_MASK       14'h3041

// reset values
`define RST_GATING_TIMERS    8'hA3
`define RST_GATING_TWO       8'h3C
`define RST_GATING_THREE     8'h36
`define RST_GATING_FOUR      8'hA9
`define RST_CRYSTAL_SC       8'h00
`define RST_EVENT_MASK       8'h00

// writable bits; the rest read as zero, except crystal control bit 0 (start-up done)
`define MASK_GATING_TIMERS   8'hA3
`define MASK_GATING_TWO      8'h3C
`define MASK_GATING_THREE    8'h36
`define MASK_GATING_FOUR     8'hA9
`define MASK_CRYSTAL_SC      8'hB6
`define MASK_EVENTS          8'h03

// crystal status and control field positions
`define BIT_AMP_ENABLE       7
`define BIT_STOP_KEEPALIVE   5
`define BIT_OUTPUT_SELECT    4
`define BIT_RANGE_HIGH       2
`define BIT_HIGH_GAIN        1
`define BIT_STARTUP_DONE     0

// first gating register field positions
`define BIT_FLEX_TIMER_TWO   7
`define BIT_FLEX_TIMER_ZERO  5
`define BIT_MODULO_TIMER     1
`define BIT_RTC              0

// event status / mask field positions
`define BIT_EV_STARTED       0
`define BIT_EV_STOPPED       1

// crystal initialization cycles
`define STARTUP_CYCLES       4096

// axi responses
`define RESP_OKAY            2'h0
`define RESP_DECERR          2'h3

`endif

// File: rtl/crystal_gate_pkg.sv
package crystal_gate_pkg;

  typedef enum logic [1:0] {
    ST_OFF      = 2'h0,
    ST_STARTING = 2'h1,
    ST_RUNNING  = 2'h3
  } xtal_state_t;

  typedef struct packed {
    logic amp_on;
    logic amp_high_gain;
    logic range_high;
    logic output_select;
    logic startup_done;
    logic clk_out;
  } xtal_ctrl_t;

  typedef struct packed {
    logic flex_timer_two_gate;
    logic flex_timer_zero_gate;
    logic modulo_timer_zero_gate;
    logic rtc_gate;
    logic [7:0] gate_two;
    logic [7:0] gate_three;
    logic [7:0] gate_four;
  } gate_ctrl_t;

  typedef struct packed {
    logic        aw_have;
    logic [13:0] aw_idx;
    logic        w_have;
    logic [7:0]  w_data;
    logic        w_lane;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [7:0]  rdata;
    logic [1:0]  rresp;
    logic [7:0]  gating_timers;
    logic [7:0]  gating_two;
    logic [7:0]  gating_three;
    logic [7:0]  gating_four;
    logic [7:0]  crystal_sc;
    logic [7:0]  ev_status;
    logic [7:0]  ev_mask;
    xtal_state_t st;
    logic [12:0] cycles;
    logic        amp_clk_prev;
    logic        clk_out;
    logic        irq;
  } state_t;

endpackage

// File: verification/crystal_gate_assertions.sv
module crystal_gate_assertions
  import crystal_gate_pkg::*;
(
  // clock and bus handshakes
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic [31:0] rdata,
  // crystal side
  input wire logic        icg_amp_request,
  input wire logic        crystal_input_pin,
  input wire logic        crystal_amp_clk,
  input wire xtal_ctrl_t  xtal_ctrl,
  input wire gate_ctrl_t  gate_ctrl
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_both_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_resp_late;
    !bvalid ##1 bvalid;
  endsequence
  AST_WRITE_RESP: assert property (s_both_taken |=> s_resp_late)
    else $error("write response late");
  AST_BVALID_HOLD: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped");
  AST_READ_RESP: assert property (arvalid && arready |=> rvalid)
    else $error("read response late");
  AST_RDATA_UPPER: assert property (rvalid |-> rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  AST_ICG_AMP: assert property (icg_amp_request |-> xtal_ctrl.amp_on)
    else $error("amplifier off under request");
  AST_DONE_DROP: assert property (!xtal_ctrl.amp_on |=> !xtal_ctrl.startup_done)
    else $error("startup flag without amplifier");
  AST_PIN_OUT: assert property (!xtal_ctrl.output_select |=>
    xtal_ctrl.clk_out == $past(crystal_input_pin)) else $error("pin clock not passed");
  AST_AMP_OUT: assert property (xtal_ctrl.output_select |=>
    xtal_ctrl.clk_out == ($past(crystal_amp_clk) & $past(xtal_ctrl.amp_on)))
    else $error("amplified clock not passed");
  AST_RESET_GATES: assert property ($rose(aresetn) |->
    gate_ctrl == {4'hF, 8'h3C, 8'h36, 8'hA9}) else $error("gate reset values");
endmodule

// File: verification/crystal_partner.sv
module crystal_partner (
  // bus clock and amplifier state
  input  wire logic aclk,
  input  wire logic amp_on,
  input  wire logic slow,
  output logic      amp_clk,
  output logic      pin_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div_q = 2'h0;
  initial amp_clk = 1'b0;
  initial pin_clk = 1'b0;
  // amplifier clock stands still while the amplifier is off
  always @(posedge aclk) begin
    div_q <= div_q + 2'h1;
    amp_clk <= amp_on & (slow ? div_q[1] : ~amp_clk);
    pin_clk <= ~pin_clk;
  end
endmodule

// File: verification/tb_top.sv
`include "crystal_gate_defs.svh"
`define CHK(nm, e, g) \
  begin \
    n_compared++; \
    if ((g) !== (e)) begin \
      failures++; \
      $display("unexpected %s exp %0h got %0h", nm, e, g); \
    end \
  end

module tb_top
  import crystal_gate_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, stop_mode = 1'b0, icg_amp_request = 1'b0;
  logic        slow = 1'b0, awready, wready, bvalid, arready, rvalid, irq, amp_clk, pin_clk;
  logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
  logic [31:0] wdata = 32'h00000000, rdata, d;
  logic [31:0] seed = 32'h39B62218;
  logic [1:0]  bresp, rresp;
  logic [13:0] i;
  logic [7:0]  v, wm [4];
  logic [7:0]  mdl [logic [13:0]];
  xtal_ctrl_t  xtal_ctrl;
  gate_ctrl_t  gate_ctrl;
  int          failures = 0, n_compared = 0;

  always #50 aclk = ~aclk;

  crystal_gate_ctrl #(.STARTUP_CYCLES(8)) dut (.*, .awprot(3'h0), .wstrb(4'hF), .arprot(3'h0),
    .crystal_input_pin(pin_clk), .crystal_amp_clk(amp_clk));
  crystal_partner model (.aclk, .amp_on(xtal_ctrl.amp_on), .slow, .amp_clk, .pin_clk);

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic wr(input logic [13:0] a, input logic [7:0] val);
    awaddr <= {a, 2'h0};
    wdata <= {24'h000000, val};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    `CHK("bresp", mdl.exists(a) ? `RESP_OKAY : `RESP_DECERR, bresp)
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rc(input logic [13:0] a);
    araddr <= {a, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    `CHK("rresp", mdl.exists(a) ? `RESP_OKAY : `RESP_DECERR, rresp)
    `CHK("rdata", mdl.exists(a) ? {24'h000000, mdl[a]} : 32'h00000000, d)
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic print_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    wm = '{`MASK_GATING_TIMERS, `MASK_GATING_TWO, `MASK_GATING_THREE, `MASK_GATING_FOUR};
    mdl[`IDX_GATING_TIMERS] = `RST_GATING_TIMERS;
    mdl[`IDX_GATING_TWO] = `RST_GATING_TWO;
    mdl[`IDX_GATING_THREE] = `RST_GATING_THREE;
    mdl[`IDX_GATING_FOUR] = `RST_GATING_FOUR;
    mdl[`IDX_CRYSTAL_SC] = 8'h00;
    mdl[`IDX_EVENT_STATUS] = 8'h00;
    mdl[`IDX_EVENT_MASK] = 8'h00;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    v = rnd();
    slow <= v[0];
    @(posedge aclk);
    foreach (mdl[k]) rc(k);
    rc(14'h3010);
    $display("test reset done");
    // no peripheral model sits behind the gates, so nothing needs quiescing first
    for (int k = 0; k < 8; k++) begin
      i = `IDX_GATING_TIMERS + 14'(k % 4);
      v = rnd();
      wr(i, v);
      mdl[i] = v & wm[k % 4];
      rc(i);
    end
    `CHK("ft2", mdl[`IDX_GATING_TIMERS][7], gate_ctrl.flex_timer_two_gate)
    `CHK("ft0", mdl[`IDX_GATING_TIMERS][5], gate_ctrl.flex_timer_zero_gate)
    `CHK("mt0", mdl[`IDX_GATING_TIMERS][1], gate_ctrl.modulo_timer_zero_gate)
    `CHK("rtc", mdl[`IDX_GATING_TIMERS][0], gate_ctrl.rtc_gate)
    `CHK("g2", mdl[`IDX_GATING_TWO], gate_ctrl.gate_two)
    `CHK("g3", mdl[`IDX_GATING_THREE], gate_ctrl.gate_three)
    `CHK("g4", mdl[`IDX_GATING_FOUR], gate_ctrl.gate_four)
    $display("test gating done");
    wr(`IDX_EVENT_MASK, 8'h03);
    mdl[`IDX_EVENT_MASK] = 8'h03;
    wr(`IDX_CRYSTAL_SC, 8'hFF);
    mdl[`IDX_CRYSTAL_SC] = 8'hFF & `MASK_CRYSTAL_SC;
    `CHK("amp", 1'b1, xtal_ctrl.amp_on)
    `CHK("osel", 1'b1, xtal_ctrl.output_select)
    `CHK("rng", 1'b1, xtal_ctrl.range_high)
    `CHK("gain", 1'b1, xtal_ctrl.amp_high_gain)
    // start-up takes a bounded number of amplifier edges; poll the flag, not the bus
    for (int n = 0; n < 200 && xtal_ctrl.startup_done !== 1'b1; n++) @(posedge aclk);
    mdl[`IDX_CRYSTAL_SC] |= 8'h01;
    rc(`IDX_CRYSTAL_SC);
    `CHK("irq", 1'b1, irq)
    mdl[`IDX_EVENT_STATUS] = 8'h01;
    rc(`IDX_EVENT_STATUS);
    mdl[`IDX_EVENT_STATUS] = 8'h00;
    @(posedge aclk);
    `CHK("irq", 1'b0, irq)
    $display("test startup done");
    stop_mode <= 1'b1;
    @(posedge aclk);
    `CHK("keep", 1'b1, xtal_ctrl.amp_on)
    wr(`IDX_CRYSTAL_SC, 8'h96);
    mdl[`IDX_CRYSTAL_SC] = 8'h96 & `MASK_CRYSTAL_SC;
    `CHK("stop", 1'b0, xtal_ctrl.amp_on)
    icg_amp_request <= 1'b1;
    repeat (2) @(posedge aclk);
    `CHK("icg", 1'b1, xtal_ctrl.amp_on)
    `CHK("irq", 1'b1, irq)
    wr(`IDX_EVENT_MASK, 8'h00);
    mdl[`IDX_EVENT_MASK] = 8'h00;
    // stay in stop mode so the dropped request stops the amplifier before it can finish
    icg_amp_request <= 1'b0;
    @(posedge aclk);
    `CHK("mask", 1'b0, irq)
    mdl[`IDX_EVENT_STATUS] = 8'h02;
    rc(`IDX_EVENT_STATUS);
    `CHK("off", 1'b0, xtal_ctrl.amp_on)
    stop_mode <= 1'b0;
    @(posedge aclk);
    $display("test stop done");
    print_verdict();
  end

  // cut a hang well past the hundred-odd cycles the tests need
  initial begin
    #2000000;
    failures++;
    print_verdict();
  end
endmodule

bind crystal_gate_ctrl crystal_gate_assertions chk (.*);
